/* File: design/lls_pkg.sv */
// lls_pkg: constants and types for the led/lcd scan control block.
// assumes a single mclk domain; registers reached over a plain strobe port.
package lls_pkg;
  localparam logic [7:0] LLS_ADDR_CTRL = 8'hB1;
  localparam logic [7:0] LLS_ADDR_CTRL2 = 8'hB2;
  // display_control fields
  localparam int LLS_ENABLE_BIT = 7;
  localparam int LLS_DUTY_LSB = 4;
  localparam int LLS_BSTYLE_BIT = 3;
  localparam int LLS_BLEVEL_LSB = 0;
  // display_control_two fields
  localparam int LLS_DIV_LSB = 5;
  localparam int LLS_FUNC_BIT = 4;
  localparam int LLS_STYLE_LSB = 0;
  localparam logic [7:0] LLS_CTRL_RESET = 8'h07;
  localparam logic [7:0] LLS_CTRL2_RESET = 8'h00;
  localparam logic [7:0] LLS_CTRL2_MASK = 8'h73;
  localparam logic [1:0] LLS_STYLE_MATRIX = 2'h0;
  localparam logic [1:0] LLS_STYLE_DOT = 2'h2;
  localparam int LLS_DIV_MAX = 64;
  // prescaler terminal counts, one less than the divide ratio
  localparam logic [5:0] LLS_DIV_LAST_64 = 6'h3F;
  localparam logic [5:0] LLS_DIV_LAST_32 = 6'h1F;
  localparam logic [5:0] LLS_DIV_LAST_16 = 6'h0F;
  localparam logic [5:0] LLS_DIV_LAST_8 = 6'h07;
  localparam int LLS_NUM_LINES = 8;

  typedef struct packed {
    logic enable;
    logic [2:0] duty;
    logic bstyle;
    logic [2:0] level;
  } lls_ctrl_t;

  typedef struct packed {
    logic rsv7;
    logic [1:0] div;
    logic led;
    logic [1:0] rsv3;
    logic [1:0] style;
  } lls_ctrl2_t;
endpackage : lls_pkg

/* File: design/lls_scan_ctrl.sv */
// lls_scan_ctrl: register pair, fast-rc-paced prescaler and common line scan.
// assumes fast_rc_clock arrives as an asynchronous level; synchronised before use.
//
// Operation
// - enable bit zero keeps whole driver idle
// - function bit selects lcd or led operation
// - style code selects matrix or dot-matrix scan
// - matrix duty codes give two to eight commons
// - brightness style bit picks uniform or enhanced
// - brightness level zero darkest, seven brightest
// - scan clock is fast rc divided 64/32/16/8
`timescale 1ns/1ps
`default_nettype none
module lls_scan_ctrl
  import lls_pkg::*;
#(
  parameter int NUM_LINES = LLS_NUM_LINES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic fast_rc_clock,
  output logic [NUM_LINES-1:0] common_line,
  output logic [NUM_LINES-1:0] dot_matrix_line,
  output logic lcd_active,
  output logic [2:0] brightness_level,
  output logic brightness_style,
  output logic scan_tick
);
  ////////////////////////////////////////////////////////////////////////
  lls_ctrl_t ctrl_reg, ctrl_next;
  lls_ctrl2_t ctrl2_reg, ctrl2_next;
  logic [7:0] rdata_reg, rdata_next;

  always_comb begin
    ctrl_next = ctrl_reg;
    ctrl2_next = ctrl2_reg;
    rdata_next = 8'h00;
    if (wr_stb && addr == LLS_ADDR_CTRL) begin
      ctrl_next = lls_ctrl_t'(wdata);
    end
    if (wr_stb && addr == LLS_ADDR_CTRL2) begin
      ctrl2_next = lls_ctrl2_t'(wdata & LLS_CTRL2_MASK);
    end
    if (rd_stb) begin
      case (addr)
        LLS_ADDR_CTRL: rdata_next = ctrl_reg;
        LLS_ADDR_CTRL2: rdata_next = ctrl2_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_reg <= lls_ctrl_t'(LLS_CTRL_RESET);
      ctrl2_reg <= lls_ctrl2_t'(LLS_CTRL2_RESET);
      rdata_reg <= 8'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      ctrl2_reg <= ctrl2_next;
      rdata_reg <= rdata_next;
    end
  end
  assign rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // fast rc edge detection: two flops, then an edge flop
  logic frc_s1_reg, frc_s2_reg, frc_s3_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      frc_s1_reg <= 1'b0;
      frc_s2_reg <= 1'b0;
      frc_s3_reg <= 1'b0;
    end else begin
      frc_s1_reg <= fast_rc_clock;
      frc_s2_reg <= frc_s1_reg;
      frc_s3_reg <= frc_s2_reg;
    end
  end
  logic frc_rise;
  assign frc_rise = frc_s2_reg & ~frc_s3_reg;

  ////////////////////////////////////////////////////////////////////////
  logic led_run;
  logic [1:0] style;
  logic [3:0] line_count;
  assign style = ctrl2_reg.style;
  // reserved style codes leave the scan stopped
  assign led_run = ctrl_reg.enable && ctrl2_reg.led
    && (style == LLS_STYLE_MATRIX || style == LLS_STYLE_DOT);

  always_comb begin
    line_count = 4'h8;
    if (style == LLS_STYLE_MATRIX) begin
      case (ctrl_reg.duty)
        3'h7: line_count = 4'h8;
        default: line_count = 4'(ctrl_reg.duty) + 4'h2;
      endcase
    end else begin
      case (ctrl_reg.duty)
        3'h0: line_count = 4'h5;
        3'h1: line_count = 4'h6;
        3'h2: line_count = 4'h7;
        3'h3: line_count = 4'h7;
        default: line_count = 4'h8;
      endcase
    end
  end

  logic [5:0] div_last;
  always_comb begin
    case (ctrl2_reg.div)
      2'h0: div_last = LLS_DIV_LAST_64;
      2'h1: div_last = LLS_DIV_LAST_32;
      2'h2: div_last = LLS_DIV_LAST_16;
      default: div_last = LLS_DIV_LAST_8;
    endcase
  end

  logic [5:0] pre_reg, pre_next;
  logic [3:0] line_reg, line_next;
  logic tick_reg, tick_next;
  always_comb begin
    pre_next = pre_reg;
    line_next = line_reg;
    tick_next = 1'b0;
    if (!led_run) begin
      pre_next = 6'h00;
      line_next = 4'h0;
    end else if (line_reg >= line_count || pre_reg > div_last) begin
      // a shrunk duty or divider restarts the slot instead of overrunning it
      pre_next = 6'h00;
      if (line_reg >= line_count) begin
        line_next = 4'h0;
      end
    end else if (frc_rise) begin
      if (pre_reg >= div_last) begin
        pre_next = 6'h00;
        tick_next = 1'b1;
        line_next = (line_reg + 4'h1 >= line_count) ? 4'h0 : line_reg + 4'h1;
      end else begin
        pre_next = pre_reg + 6'h01;
      end
    end
  end

  // one-hot line drive; the selected pin set depends on scan style
  logic [NUM_LINES-1:0] com_reg, com_next, dot_reg, dot_next;
  always_comb begin
    com_next = '0;
    dot_next = '0;
    if (led_run && style == LLS_STYLE_MATRIX && line_reg < line_count) begin
      com_next[line_reg[2:0]] = 1'b1;
    end
    if (led_run && style == LLS_STYLE_DOT && line_reg < line_count) begin
      dot_next[line_reg[2:0]] = 1'b1;
    end
  end

  logic lcd_reg, lcd_next;
  logic [2:0] lvl_reg;
  logic bsty_reg;
  assign lcd_next = ctrl_reg.enable && !ctrl2_reg.led;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pre_reg <= 6'h00;
      line_reg <= 4'h0;
      tick_reg <= 1'b0;
      com_reg <= '0;
      dot_reg <= '0;
      lcd_reg <= 1'b0;
      lvl_reg <= 3'h0;
      bsty_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      line_reg <= line_next;
      tick_reg <= tick_next;
      com_reg <= com_next;
      dot_reg <= dot_next;
      lcd_reg <= lcd_next;
      lvl_reg <= ctrl_reg.enable ? ctrl_reg.level : 3'h0;
      bsty_reg <= ctrl_reg.enable & ctrl_reg.bstyle;
    end
  end
  assign common_line = com_reg;
  assign dot_matrix_line = dot_reg;
  assign lcd_active = lcd_reg;
  assign brightness_level = lvl_reg;
  assign brightness_style = bsty_reg;
  assign scan_tick = tick_reg;

  ////////////////////////////////////////////////////////////////////////
  property p_idle_when_off;
    @(posedge mclk) disable iff (sys_rst)
      !ctrl_reg.enable |=> (common_line == '0 && dot_matrix_line == '0 && !lcd_active);
  endproperty
  a_idle_when_off: assert property (p_idle_when_off) else $error("driver active while off");

  property p_lcd_mode;
    @(posedge mclk) disable iff (sys_rst)
      (ctrl_reg.enable && !ctrl2_reg.led) |=> (lcd_active && common_line == '0);
  endproperty
  a_lcd_mode: assert property (p_lcd_mode) else $error("lcd mode not honoured");

  property p_reserved_style;
    @(posedge mclk) disable iff (sys_rst)
      (style == 2'h1 || style == 2'h3) |=> (common_line == '0 && dot_matrix_line == '0);
  endproperty
  a_reserved_style: assert property (p_reserved_style) else $error("reserved style scans");

  property p_matrix_bound;
    @(posedge mclk) disable iff (sys_rst)
      led_run && $stable(ctrl_reg.duty) && $stable(style) |-> line_reg < line_count;
  endproperty
  a_matrix_bound: assert property (p_matrix_bound) else $error("line beyond duty");

  property p_style_out;
    @(posedge mclk) disable iff (sys_rst)
      ctrl_reg.enable |=> brightness_style == $past(ctrl_reg.bstyle);
  endproperty
  a_style_out: assert property (p_style_out) else $error("style mismatch");

  property p_level_out;
    @(posedge mclk) disable iff (sys_rst)
      ctrl_reg.enable |=> brightness_level == $past(ctrl_reg.level);
  endproperty
  a_level_out: assert property (p_level_out) else $error("level mismatch");

  property p_div_bound;
    @(posedge mclk) disable iff (sys_rst)
      led_run && $stable(ctrl2_reg.div) |-> pre_reg <= div_last;
  endproperty
  a_div_bound: assert property (p_div_bound) else $error("prescaler overran");

  property p_wrap;
    @(posedge mclk) disable iff (sys_rst)
      (led_run && frc_rise && pre_reg >= div_last && line_reg + 4'h1 >= line_count)
        |=> line_reg == 4'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("scan did not wrap");
endmodule : lls_scan_ctrl
`default_nettype wire

/* File: sim/lls_panel_model.sv */
// lls_panel_model: far side source of the fast rc oscillator level.
// assumes the design synchronises fast_rc_clock; counts rising edges for the bench.
`timescale 1ns/1ps
`default_nettype none
module lls_panel_model (
  output logic fast_rc_clock,
  output int rc_edges
);
  ////////////////////////////////////////
  // 41 ns period: below mclk/4; the offset keeps every edge off an mclk edge
  initial begin
    fast_rc_clock = 1'b0;
    rc_edges = 0;
    #1.2;
    forever begin
      #20.5 fast_rc_clock = ~fast_rc_clock;
      if (fast_rc_clock) rc_edges++;
    end
  end
endmodule : lls_panel_model
`default_nettype wire

/* File: sim/lls_scan_ctrl_tb.sv */
// led_lcd_scan_control_tb_top: self-checking bench for lls_scan_ctrl.
// assumes lls_pkg and lls_panel_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module led_lcd_scan_control_tb_top;
  import lls_pkg::*;
  logic mclk, sys_rst, wr_stb, rd_stb, fast_rc_clock, lcd_active, scan_tick, brightness_style;
  logic [7:0] addr, wdata, rdata, common_line, dot_matrix_line;
  logic [2:0] brightness_level;
  int rc_edges, e0;
  int err_count = 0;
  int n_tests = 0;
  lls_scan_ctrl #(.NUM_LINES(8)) i_lls_scan_ctrl (.mclk(mclk), .sys_rst(sys_rst),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .fast_rc_clock(fast_rc_clock), .common_line(common_line),
    .dot_matrix_line(dot_matrix_line), .lcd_active(lcd_active),
    .brightness_level(brightness_level), .brightness_style(brightness_style),
    .scan_tick(scan_tick));
  lls_panel_model i_lls_panel_model (.fast_rc_clock(fast_rc_clock), .rc_edges(rc_edges));
  ////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  task automatic summarize;
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask : rd
  task automatic wait_tick;
    int i;
    for (i = 0; i < 4000 && scan_tick !== 1'b1; i++) @(negedge mclk);
    if (i == 4000) begin
      err_count++;
      $display("[FAIL] scan_tick expected 1 seen 0");
      summarize();
    end
    @(negedge mclk);
  endtask : wait_tick
  // one slot per tick; n ticks must land back on line 0
  task automatic t_scan(input logic [7:0] c2, input logic [7:0] c1, input int n, input int dv);
    wr(LLS_ADDR_CTRL2, c2);
    wr(LLS_ADDR_CTRL, c1);
    for (int k = 1; k <= n; k++) begin
      wait_tick();
      if (k == 1) e0 = rc_edges;
      if (k == 2) chk("divider", 8'(dv), 8'(rc_edges - e0));
      repeat (2) @(negedge mclk);
      chk("line", 8'h01 << (k % n), c2[1] ? dot_matrix_line : common_line);
      chk("other", 8'h00, c2[1] ? common_line : dot_matrix_line);
      chk("lcd_in_led", 8'h00, {7'h00, lcd_active});
    end
  endtask : t_scan
  task automatic t_lcd;
    wr(LLS_ADDR_CTRL2, 8'h00);
    wr(LLS_ADDR_CTRL, 8'h8A);
    repeat (3) @(negedge mclk);
    chk("lcd", 8'h01, {7'h00, lcd_active});
    chk("com", 8'h00, common_line);
    chk("level", 8'h02, {5'h00, brightness_level});
    chk("style", 8'h01, {7'h00, brightness_style});
    wr(LLS_ADDR_CTRL, 8'h0F);
    repeat (3) @(negedge mclk);
    chk("off", 8'h00, {3'h0, brightness_style, lcd_active, brightness_level});
  endtask : t_lcd
  task automatic t_regs;
    rd(LLS_ADDR_CTRL, LLS_CTRL_RESET);
    rd(LLS_ADDR_CTRL2, LLS_CTRL2_RESET);
    rd(8'hB3, 8'h00);
    wr(LLS_ADDR_CTRL2, 8'hFF);
    rd(LLS_ADDR_CTRL2, 8'h73);
  endtask : t_regs
  // a running matrix scan must fall silent once the enable bit clears
  task automatic t_off;
    wr(LLS_ADDR_CTRL2, 8'h70);
    wr(LLS_ADDR_CTRL, 8'h80);
    repeat (3) @(negedge mclk);
    chk("on", 8'h01, common_line);
    wr(LLS_ADDR_CTRL, 8'h00);
    repeat (3) @(negedge mclk);
    chk("idle", 8'h00, common_line | dot_matrix_line);
  endtask : t_off
  task automatic t_reserved(input logic [7:0] c2);
    wr(LLS_ADDR_CTRL2, c2);
    wr(LLS_ADDR_CTRL, 8'h80);
    repeat (200) @(negedge mclk);
    chk("reserved", 8'h00, common_line | dot_matrix_line);
  endtask : t_reserved
  ////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    t_regs();
    t_scan(8'h70, 8'h80, 2, 8);
    t_scan(8'h30, 8'hF0, 8, 32);
    t_scan(8'h52, 8'h80, 5, 16);
    t_scan(8'h12, 8'hD0, 8, 64);
    t_lcd();
    t_off();
    t_reserved(8'h71);
    t_reserved(8'h73);
    summarize();
  end
endmodule : led_lcd_scan_control_tb_top
`default_nettype wire
